// ### rtl/rac_pkg.sv
// Function
// RL1 - Running application code: C0 app, 80 boot
// RL2 - Start application written into request register
// RL3 - Host polls code at 0x00 until matched
// RL4 - Command 0A triggers algorithm calibration
// RL5 - Calibration yields data set host must keep
// RL6 - Host reloads calibration before commands 02/0B
// RL7 - Iterations and threshold set through registers
// RL8 - Default parameters A3, 00, 04, D8
// RL9 - Closest object distance in millimetre steps
// RL10 - Host treats above 2500 mm as none
// RL11 - Ranging period programmable, at most 209 ms
// RL12 - Ranging nominally 33 ms, varies with mode
// RL13 - 8 ms init at start or temperature change
// RL14 - Boot takes nominally 3 ms
// RL15 - Ready within 8 ms after enable high
// RL16 - Long mode from 200 mm object distance
// RL17 - Long mode uses reduced detector array
// RL18 - Host tunes oscillator to 4.7 MHz
// RL19 - Register pointer auto-increments, survives STOP
// RL20 - Target address 0x41, changeable after power-up
// RL21 - Running code holds until new application starts
package rac_pkg;
	// Clock and time base
	localparam int unsigned CLK_HZ = 10_000_000;
	localparam int unsigned MS_PER_S = 1000;
	// Application codes
	localparam logic [7:0] APP_NONE = 8'h00;
	localparam logic [7:0] APP_BOOT = 8'h80;
	localparam logic [7:0] APP_MEAS = 8'hC0;
	// Register offsets
	localparam logic [7:0] REG_APP = 8'h00;
	localparam logic [7:0] REG_REV = 8'h01;
	localparam logic [7:0] REG_REQ = 8'h02;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_PARAM0 = 8'h11;
	localparam logic [7:0] REG_PERIOD = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h19;
	localparam logic [7:0] REG_DIST_LO = 8'h1A;
	localparam logic [7:0] REG_DIST_HI = 8'h1B;
	localparam logic [7:0] REG_DEVADDR = 8'h1C;
	localparam logic [7:0] REG_CAL_BASE = 8'h20;
	localparam int unsigned PARAM_COUNT = 7;
	// Status bit positions
	localparam int unsigned ST_READY = 0;
	localparam int unsigned ST_BUSY = 1;
	localparam int unsigned ST_LONG = 2;
	localparam int unsigned ST_CAL_LOADED = 3;
	localparam int unsigned ST_RESULT = 4;
	localparam int unsigned ST_CAL_DONE = 5;
	// Command codes
	localparam logic [7:0] CMD_MEAS_PERIODIC = 8'h02;
	localparam logic [7:0] CMD_MEAS_SINGLE = 8'h03;
	localparam logic [7:0] CMD_CALIBRATE = 8'h0A;
	localparam logic [7:0] CMD_ALGO_SINGLE = 8'h0B;
	localparam logic [7:0] CMD_STOP = 8'hFF;
	// Reset values
	localparam logic [7:0] PARAM6_RST = 8'hA3;
	localparam logic [7:0] PARAM3_RST = 8'h00;
	localparam logic [7:0] PARAM1_RST = 8'h04;
	localparam logic [7:0] PARAM0_RST = 8'hD8;
	localparam logic [7:0] PARAM_RST = 8'h00;
	localparam logic [7:0] PERIOD_RST = 8'h00;
	localparam logic [6:0] DEV_ADDR_RST = 7'h41;
	// Timing in milliseconds, distances in millimetres
	localparam logic [7:0] BOOT_MS = 8'd3;
	localparam logic [7:0] INIT_MS = 8'd8;
	localparam logic [7:0] READY_MS = 8'd8;
	localparam logic [7:0] RANGE_MS = 8'd33;
	localparam logic [7:0] PERIOD_MAX_MS = 8'd209;
	localparam logic [15:0] LONG_MODE_MM = 16'd200;
	localparam logic [15:0] NO_OBJECT_MM = 16'hFFFF;
	localparam logic [23:0] DEFAULT_ITER_K = {8'h00, PARAM1_RST, PARAM0_RST};
	// Sequencer states
	typedef enum logic [2:0] {
		st_off, st_boot, st_idle, st_init, st_meas, st_wait, st_cal
	} rac_state_e;
endpackage : rac_pkg

// ### rtl/rac_ranging_control.sv
`timescale 1ns/1ps
`default_nettype none
module rac_ranging_control
	import rac_pkg::*;
#(
	parameter int unsigned MS_CYCLES = CLK_HZ / MS_PER_S,
	parameter int unsigned CAL_BYTES = 16,
	parameter logic [7:0] APP_MAJOR_REV = 8'h01
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Pins
	input wire logic enable_pin,
	input wire logic temp_changed,
	// Byte port from the serial front end
	input wire logic bus_addr_valid,
	input wire logic [6:0] bus_addr,
	input wire logic bus_read,
	output logic bus_addr_ack,
	input wire logic bus_wr_valid,
	input wire logic [7:0] bus_wr_data,
	input wire logic bus_rd_req,
	output logic [7:0] bus_rd_data,
	input wire logic bus_stop,
	// Echo results from signal processing
	input wire logic echo_valid,
	input wire logic [15:0] echo_mm,
	input wire logic [7:0] echo_strength,
	// Analog and algorithm control
	output logic [15:0] iteration_count,
	output logic [7:0] detect_threshold,
	output logic photon_detector_array_reduced,
	output logic emitter_active,
	output logic elec_cal_active,
	output logic device_ready
);
	localparam int MS_W = $clog2(MS_CYCLES);
	localparam int CAL_IW = $clog2(CAL_BYTES);

	////////////////////////////////////////////////////////////////////////
	// Declarations
	logic en_meta, en_s, tc_meta, tc_s, tc_d;
	logic [MS_W-1:0] ms_cnt;
	logic [7:0] tmr, rdy_ms;
	rac_state_e state, next_state;
	logic [7:0] running_application, application_major_revision;
	logic [7:0] application_request, command_last, period_ms;
	logic [7:0] param [PARAM_COUNT];
	logic [7:0] cal_mem [CAL_BYTES];
	logic [CAL_IW-1:0] cal_idx;
	logic [6:0] dev_addr;
	logic [7:0] ptr, boot_target;
	logic selected, expect_ptr, req_pend, need_init, periodic, cal_mode;
	logic long_mode, cal_loaded, result_new, cal_done;
	logic [15:0] closest, distance;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and millisecond tick
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			{en_meta, en_s, tc_meta, tc_s, tc_d} <= 5'h00;
		end
		else
		begin
			{en_meta, en_s} <= {enable_pin, en_meta};
			{tc_meta, tc_s, tc_d} <= {temp_changed, tc_meta, tc_s};
		end

	wire temp_rise = tc_s & ~tc_d;
	wire ms_tick = ms_cnt == MS_W'(MS_CYCLES - 1);

	// Free-running divider, so state timers are nominal to one tick
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
			ms_cnt <= '0;
		else
			ms_cnt <= ms_tick ? '0 : ms_cnt + 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Byte port decode
	wire addr_hit = en_s && bus_addr == dev_addr; // [RL20]
	assign bus_addr_ack = bus_addr_valid && addr_hit;
	wire wr_en = bus_wr_valid && selected && !expect_ptr;
	wire rd_en = bus_rd_req && selected;
	wire wr_req = wr_en && ptr == REG_REQ;
	wire wr_cmd = wr_en && ptr == REG_CMD;
	wire wr_status = wr_en && ptr == REG_STATUS;
	wire [7:0] cal_off = ptr - REG_CAL_BASE;
	wire in_cal = ptr >= REG_CAL_BASE && cal_off < 8'(CAL_BYTES);
	wire [7:0] par_off = ptr - REG_PARAM0;
	wire in_par = ptr >= REG_PARAM0 && par_off < 8'(PARAM_COUNT);
	wire app_ok = running_application == APP_MEAS;
	wire go_cmd = wr_cmd && app_ok && (bus_wr_data == CMD_MEAS_PERIODIC
		|| bus_wr_data == CMD_MEAS_SINGLE || bus_wr_data == CMD_ALGO_SINGLE);
	wire cal_cmd = wr_cmd && app_ok && bus_wr_data == CMD_CALIBRATE; // [RL4]
	wire stop_cmd = wr_cmd && bus_wr_data == CMD_STOP;
	wire valid_app = bus_wr_data == APP_BOOT || bus_wr_data == APP_MEAS;
	wire [7:0] status = {2'b00, cal_done, result_new, cal_loaded, long_mode,
		state == st_meas || state == st_wait, device_ready};

	// Register read selection
	function automatic logic [7:0] read_reg(input logic [7:0] a);
		if (a == REG_APP)
			return running_application;
		else if (a == REG_REV)
			return application_major_revision;
		else if (a == REG_REQ)
			return application_request;
		else if (a == REG_CMD)
			return command_last;
		else if (in_par)
			return param[par_off[2:0]];
		else if (a == REG_PERIOD)
			return period_ms;
		else if (a == REG_STATUS)
			return status;
		else if (a == REG_DIST_LO)
			return distance[7:0];
		else if (a == REG_DIST_HI)
			return distance[15:8];
		else if (a == REG_DEVADDR)
			return {1'b0, dev_addr};
		else if (in_cal)
			return cal_mem[cal_off[CAL_IW-1:0]];
		return 8'h00;
	endfunction : read_reg

	// Pointer survives STOP; only a write's first byte reloads it
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			selected <= 1'b0;
			expect_ptr <= 1'b0;
			ptr <= 8'h00;
			bus_rd_data <= 8'h00;
		end
		else if (bus_addr_valid)
		begin
			selected <= addr_hit;
			expect_ptr <= addr_hit && !bus_read;
		end
		else if (bus_stop)
			selected <= 1'b0;
		else if (bus_wr_valid && selected)
		begin
			expect_ptr <= 1'b0;
			ptr <= expect_ptr ? bus_wr_data : ptr + 8'h01; // [RL19]
		end
		else if (rd_en)
		begin
			bus_rd_data <= read_reg(ptr);
			ptr <= ptr + 8'h01; // [RL19]
		end

	////////////////////////////////////////////////////////////////////////
	// Measurement duration scales with iterations; default gives 33 ms
	wire [23:0] iter_k = {8'h00, param[1], param[0]};
	wire [31:0] dur_q = (32'(iter_k) * 32'(RANGE_MS) + 32'(DEFAULT_ITER_K >> 1))
		/ 32'(DEFAULT_ITER_K);
	wire [7:0] dur_ms = dur_q > 32'd255 ? 8'hFF :
		dur_q == 32'd0 ? 8'h01 : dur_q[7:0]; // [RL12]
	wire [7:0] wait_ms = period_ms > dur_ms ? period_ms - dur_ms : 8'h00;

	// Sequencer
	always_comb
	begin
		next_state = state;
		if (!en_s)
			next_state = st_off;
		else
			unique case (state)
				st_off: next_state = st_boot;
				st_boot: if (tmr >= BOOT_MS) next_state = st_idle; // [RL14]
				st_idle:
					if (req_pend)
						next_state = st_boot;
					else if (go_cmd || cal_cmd)
						next_state = need_init ? st_init :
							cal_cmd ? st_cal : st_meas;
				st_init:
					if (stop_cmd)
						next_state = st_idle;
					else if (tmr >= INIT_MS) // [RL13]
						next_state = cal_mode ? st_cal : st_meas;
				st_meas:
					if (stop_cmd)
						next_state = st_idle;
					else if (tmr >= dur_ms)
						next_state = periodic ? st_wait : st_idle;
				st_wait:
					if (stop_cmd)
						next_state = st_idle;
					else if (tmr >= wait_ms) // [RL11]
						next_state = need_init ? st_init : st_meas; // [RL13]
				st_cal: if (tmr >= RANGE_MS) next_state = st_idle; // [RL5]
				// Unused state code falls back to power-off
				default: next_state = st_off;
			endcase
	end

	wire state_chg = next_state != state;
	wire meas_end = state == st_meas && next_state != st_meas && !stop_cmd;

	// State, timers and registered control outputs
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			state <= st_off;
			tmr <= 8'h00;
			rdy_ms <= 8'h00;
			emitter_active <= 1'b0;
			elec_cal_active <= 1'b0;
			device_ready <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tmr <= state_chg ? 8'h00 : tmr + 8'(ms_tick && tmr != 8'hFF);
			rdy_ms <= !en_s ? 8'h00 : rdy_ms + 8'(ms_tick && rdy_ms < READY_MS);
			device_ready <= en_s && rdy_ms >= READY_MS; // [RL15]
			emitter_active <= next_state == st_meas || next_state == st_cal;
			elec_cal_active <= next_state == st_init;
		end

	// Application selection
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			running_application <= APP_NONE; // [RL1]
			application_major_revision <= 8'h00;
			application_request <= 8'h00;
			boot_target <= APP_BOOT;
			req_pend <= 1'b0;
		end
		else
		begin
			if (wr_en && ptr == REG_REV)
				application_major_revision <= bus_wr_data;
			if (wr_req)
				application_request <= bus_wr_data;
			// A request written while booting is kept, not lost
			if (wr_req && valid_app)
				req_pend <= 1'b1; // [RL2]
			else if (state == st_idle && next_state == st_boot)
				req_pend <= 1'b0;
			if (state == st_off)
			begin
				running_application <= APP_NONE;
				boot_target <= APP_BOOT;
			end
			else if (state == st_idle && next_state == st_boot)
				boot_target <= application_request; // [RL2]
			// Code changes only once the new application runs
			if (state == st_boot && next_state == st_idle)
			begin
				running_application <= boot_target; // [RL21] [RL1]
				application_major_revision <= APP_MAJOR_REV;
			end
		end

	// Command, parameter and address registers
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			command_last <= 8'h00;
			period_ms <= PERIOD_RST;
			dev_addr <= DEV_ADDR_RST; // [RL20]
			periodic <= 1'b0;
			cal_mode <= 1'b0;
			for (int i = 0; i < PARAM_COUNT; i++)
				param[i] <= PARAM_RST;
			param[0] <= PARAM0_RST; // [RL8]
			param[1] <= PARAM1_RST; // [RL8]
			param[3] <= PARAM3_RST; // [RL8]
			param[6] <= PARAM6_RST; // [RL8]
		end
		else
		begin
			if (wr_cmd)
				command_last <= bus_wr_data;
			if (state == st_idle && (go_cmd || cal_cmd))
			begin
				periodic <= bus_wr_data == CMD_MEAS_PERIODIC;
				cal_mode <= cal_cmd;
			end
			if (wr_en && in_par)
				param[par_off[2:0]] <= bus_wr_data; // [RL7]
			if (wr_en && ptr == REG_PERIOD) // Longer requests are clamped
				period_ms <= bus_wr_data > PERIOD_MAX_MS ?
					PERIOD_MAX_MS : bus_wr_data; // [RL11]
			if (wr_en && ptr == REG_DEVADDR)
				dev_addr <= bus_wr_data[6:0]; // [RL20]
		end

	////////////////////////////////////////////////////////////////////////
	// Closest echo search and result
	wire echo_ok = echo_valid && echo_strength > param[3]; // [RL7]
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			closest <= NO_OBJECT_MM;
			distance <= NO_OBJECT_MM;
			long_mode <= 1'b0;
		end
		else if (state != st_meas)
			closest <= NO_OBJECT_MM;
		else if (meas_end)
		begin
			distance <= closest; // [RL9]
			long_mode <= closest >= LONG_MODE_MM; // [RL16]
		end
		else if (echo_ok && echo_mm < closest)
			closest <= echo_mm; // [RL9]

	// Sticky flags: hardware set wins over software clear
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			need_init <= 1'b1;
			result_new <= 1'b0;
			cal_done <= 1'b0;
			cal_loaded <= 1'b0;
		end
		else
		begin
			if (state == st_off || temp_rise)
				need_init <= 1'b1; // [RL13]
			else if (state == st_init && next_state != st_init && !stop_cmd)
				need_init <= 1'b0;
			if (meas_end)
				result_new <= 1'b1;
			else if (wr_status && bus_wr_data[ST_RESULT])
				result_new <= 1'b0;
			if (state == st_cal && next_state == st_idle)
				cal_done <= 1'b1; // [RL5]
			else if (wr_status && bus_wr_data[ST_CAL_DONE])
				cal_done <= 1'b0;
			if (state == st_off)
				cal_loaded <= 1'b0;
			else if (wr_en && in_cal && cal_off == 8'(CAL_BYTES - 1))
				cal_loaded <= 1'b1; // [RL6]
		end

	// Calibration store: device fills it, host reads it out and back
	always_ff @(posedge clk_sys or posedge reset)
		if (reset)
		begin
			cal_idx <= '0;
			for (int i = 0; i < CAL_BYTES; i++)
				cal_mem[i] <= 8'h00;
		end
		else if (state == st_cal)
		begin
			if (echo_valid)
			begin
				cal_mem[cal_idx] <= echo_strength; // [RL5]
				cal_idx <= cal_idx + 1'b1;
			end
		end
		else
		begin
			cal_idx <= '0;
			if (wr_en && in_cal)
				cal_mem[cal_off[CAL_IW-1:0]] <= bus_wr_data; // [RL6]
		end

	// Algorithm settings and array selection
	assign iteration_count = {param[1], param[0]}; // [RL7]
	assign detect_threshold = param[3]; // [RL7]
	assign photon_detector_array_reduced = long_mode; // [RL17]
endmodule : rac_ranging_control
`default_nettype wire

// ### verification/rac_chk.sv
`timescale 1ns/1ps
`default_nettype none
module rac_chk
	import rac_pkg::*;
#(
	parameter int unsigned MS_CYCLES = CLK_HZ / MS_PER_S
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Watched ports
	input wire logic enable_pin,
	input wire logic bus_addr_valid,
	input wire logic [6:0] bus_addr,
	input wire logic bus_addr_ack,
	input wire logic bus_wr_valid,
	input wire logic bus_rd_req,
	input wire logic [7:0] bus_rd_data,
	input wire logic [15:0] iteration_count,
	input wire logic [7:0] detect_threshold,
	input wire logic photon_detector_array_reduced,
	input wire logic emitter_active,
	input wire logic elec_cal_active,
	input wire logic device_ready
);
	localparam int MS = int'(MS_CYCLES);
	localparam int LO8 = 7 * MS;
	localparam int HI8 = 8 * MS + 4;
	localparam int LO33 = 32 * MS - 1;
	localparam int HI33 = 33 * MS + 1;
	int init_run;
	int emit_run;
	int en_run;
	////////////////////////////////////////////////////////////
	// Run lengths; enable count saturates so long runs never wrap
	always_ff @(posedge clk_sys or posedge reset)
	begin
		if (reset)
		begin
			init_run <= 0;
			emit_run <= 0;
			en_run <= 0;
		end
		else
		begin
			init_run <= elec_cal_active ? init_run + 1 : 0;
			emit_run <= emitter_active ? emit_run + 1 : 0;
			en_run <= !enable_pin ? 0 : (en_run < 99999 ? en_run + 1 : en_run);
		end
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	ack_valid_a: assert property (bus_addr_ack |->
		bus_addr_valid && $past(enable_pin, 2))
		else $error("address ack outside address phase or while off");
	ack_default_a: assert property (bus_addr_valid && device_ready &&
		bus_addr == DEV_ADDR_RST |-> bus_addr_ack)
		else $error("default target address not acked");
	init_apart_a: assert property (elec_cal_active |-> !emitter_active)
		else $error("emitter active during init");
	init_length_a: assert property ($fell(elec_cal_active) |->
		init_run >= LO8 - 1 && init_run <= HI8)
		else $error("init length wrong");
	range_length_a: assert property ($fell(emitter_active) &&
		iteration_count == DEFAULT_ITER_K[15:0] |->
		emit_run >= LO33 && emit_run <= HI33)
		else $error("default ranging length wrong");
	ready_late_a: assert property (en_run >= HI8 |-> device_ready)
		else $error("ready too late");
	ready_early_a: assert property ($rose(device_ready) |-> en_run >= LO8)
		else $error("ready too early");
	param_write_a: assert property ($changed(iteration_count) ||
		$changed(detect_threshold) |-> $past(bus_wr_valid))
		else $error("algorithm setting changed without write");
	long_end_a: assert property ($changed(photon_detector_array_reduced)
		|-> $past(emitter_active) || $past(emitter_active, 2))
		else $error("array mode changed outside measure end");
	rd_hold_a: assert property (!$past(bus_rd_req) |-> $stable(bus_rd_data))
		else $error("read data changed without request");
	cover property ($rose(elec_cal_active));
	cover property ($rose(photon_detector_array_reduced));
	cover property ($fell(emitter_active));
	// Periodic ranging: next measurement follows a short wait
	cover property ($fell(emitter_active) ##[1:HI8] $rose(emitter_active));
endmodule : rac_chk
bind rac_ranging_control rac_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (.clk_sys,
	.reset, .enable_pin, .bus_addr_valid, .bus_addr, .bus_addr_ack,
	.bus_wr_valid, .bus_rd_req, .bus_rd_data, .iteration_count,
	.detect_threshold, .photon_detector_array_reduced, .emitter_active,
	.elec_cal_active, .device_ready);
`default_nettype wire

// ### verification/rac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rac_host_model
	import rac_pkg::*;
#(
	parameter logic [6:0] TARGET = 7'h41
)
(
	// Clock
	input wire logic clk_sys,
	// Byte port towards the device
	output logic bus_addr_valid,
	output logic [6:0] bus_addr,
	output logic bus_read,
	input wire logic bus_addr_ack,
	output logic bus_wr_valid,
	output logic [7:0] bus_wr_data,
	output logic bus_rd_req,
	input wire logic [7:0] bus_rd_data,
	output logic bus_stop
);
	logic ack_seen = 1'b0;
	logic [7:0] rd_seen = 8'h00;
	// Idle bus at time zero
	initial
	begin
		{bus_addr_valid, bus_read, bus_wr_valid, bus_rd_req, bus_stop} = 5'h00;
		bus_addr = 7'h00;
		bus_wr_data = 8'h00;
	end
	////////////////////////////////////////////////////////////
	// One cycle; unqualified lines flip so stale data never looks valid
	task automatic cyc(input logic [4:0] k, input logic [7:0] v);
		@(posedge clk_sys);
		ack_seen = bus_addr_ack;
		#1;
		rd_seen = bus_rd_data;
		{bus_addr_valid, bus_read, bus_wr_valid, bus_rd_req, bus_stop} = k;
		bus_addr = k[4] ? v[6:0] : ~bus_addr;
		bus_wr_data = k[2] ? v : ~bus_wr_data;
	endtask : cyc
	// Address phase alone, then STOP
	task automatic probe(input logic [6:0] a, output logic ack);
		cyc(5'h10, {1'b0, a});
		cyc(5'h01, 8'h00);
		ack = ack_seen;
		cyc(5'h00, 8'h00);
	endtask : probe
	// Pointer byte, one data byte, STOP
	task automatic wr_reg(input logic [7:0] r, input logic [7:0] v);
		cyc(5'h10, {1'b0, TARGET});
		cyc(5'h04, r);
		cyc(5'h04, v);
		cyc(5'h01, 8'h00);
		cyc(5'h00, 8'h00);
	endtask : wr_reg
	// Read without pointer byte: continues where the pointer stands
	task automatic rd_next(output logic [7:0] v);
		cyc(5'h18, {1'b0, TARGET});
		cyc(5'h02, 8'h00);
		cyc(5'h01, 8'h00);
		v = rd_seen;
		cyc(5'h00, 8'h00);
	endtask : rd_next
	task automatic rd_reg(input logic [7:0] r, output logic [7:0] v);
		cyc(5'h10, {1'b0, TARGET});
		cyc(5'h04, r);
		rd_next(v);
	endtask : rd_reg
endmodule : rac_host_model
`default_nettype wire

// ### verification/ranging_app_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module ranging_app_control_tb_top;
	import rac_pkg::*;
	localparam int unsigned MSC = 10;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic enable_pin = 1'b0;
	logic temp_changed = 1'b0;
	logic bus_addr_valid, bus_read, bus_addr_ack, bus_wr_valid, bus_rd_req;
	logic bus_stop, echo_valid, ack;
	logic [6:0] bus_addr;
	logic [7:0] bus_wr_data, bus_rd_data, echo_strength, detect_threshold, d, h;
	logic [7:0] near_st = 8'h03, far_st = 8'h20;
	logic [15:0] echo_mm, iteration_count;
	logic photon_detector_array_reduced, emitter_active, elec_cal_active;
	logic device_ready;
	int fail_count = 0, total_checks = 0, init_cyc = 0, emit_cyc = 0, n = 0;
	// Stands for the tuned oscillator; ms timing follows MS_CYCLES
	always #50 clk_sys = ~clk_sys;
	// Near and far returns alternate while the emitter runs
	always @(posedge clk_sys)
	begin
		#1;
		n = n + 1;
		echo_valid = emitter_active && n[2:0] == 3'h0;
		echo_mm = n[3] ? 16'd300 : 16'd150;
		echo_strength = n[3] ? far_st : near_st;
		init_cyc = init_cyc + int'(elec_cal_active);
		emit_cyc = emit_cyc + int'(emitter_active);
	end
	initial echo_valid = 1'b0;
	rac_ranging_control #(.MS_CYCLES(MSC)) dut (.clk_sys, .reset, .enable_pin,
		.temp_changed, .bus_addr_valid, .bus_addr, .bus_read, .bus_addr_ack,
		.bus_wr_valid, .bus_wr_data, .bus_rd_req, .bus_rd_data, .bus_stop,
		.echo_valid, .echo_mm, .echo_strength, .iteration_count,
		.detect_threshold, .photon_detector_array_reduced, .emitter_active,
		.elec_cal_active, .device_ready);
	rac_host_model host (.clk_sys, .bus_addr_valid, .bus_addr, .bus_read,
		.bus_addr_ack, .bus_wr_valid, .bus_wr_data, .bus_rd_req, .bus_rd_data,
		.bus_stop);
	////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic chk_rng(input string s, input int lo, input int hi, input int g);
		chk(s, 16'h0, 16'(g < lo || g > hi));
	endtask : chk_rng
	// Bounded poll of one status bit
	task automatic wait_bit(input int b);
		d = 8'h00;
		for (int i = 0; i < 300 && d[b] !== 1'b1; i++)
			host.rd_reg(REG_STATUS, d);
		if (d[b] !== 1'b1)
		begin
			chk("status_wait", 16'h1, 16'h0);
			print_verdict();
		end
	endtask : wait_bit
	// Single shot; threshold filters the weak near return
	task automatic measure(input logic [7:0] thr, input logic [15:0] e, input int ini);
		host.wr_reg(REG_PARAM0 + 8'h03, thr);
		chk("threshold", 16'(thr), 16'(detect_threshold));
		init_cyc = 0;
		emit_cyc = 0;
		host.wr_reg(REG_CMD, CMD_MEAS_SINGLE);
		wait_bit(ST_RESULT);
		host.wr_reg(REG_STATUS, 8'h10);
		host.rd_reg(REG_DIST_LO, d);
		host.rd_next(h);
		chk("distance", e, {h, d});
		chk("long_mode", 16'(e >= 16'd200), 16'(photon_detector_array_reduced));
		chk_rng("init_cycles", ini * 7 * MSC, ini * (8 * MSC + 1), init_cyc);
		chk_rng("range_cycles", 32 * MSC, 33 * MSC + 1, emit_cyc);
	endtask : measure
	task automatic print_verdict();
		$display("Checks %0d, errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	////////////////////////////////////////////////////////////
	initial
	begin
		#3_000_000;
		chk("run_time", 16'h0, 16'h1);
		print_verdict();
	end
	// Main sequence
	initial
	begin
		repeat (8) @(posedge clk_sys);
		#1;
		reset = 1'b0;
		host.probe(7'h41, ack);
		chk("ack_while_off", 16'h0, 16'(ack));
		enable_pin = 1'b1;
		repeat (90) @(posedge clk_sys);
		#1;
		chk("device_ready", 16'h1, 16'(device_ready));
		host.probe(7'h42, ack);
		chk("ack_other_addr", 16'h0, 16'(ack));
		host.rd_reg(REG_APP, d);
		chk("app_boot", 16'(APP_BOOT), 16'(d));
		host.rd_reg(REG_REQ, d);
		chk("request_reset", 16'h0, 16'(d));
		host.rd_reg(8'hF0, d);
		chk("unmapped", 16'h0, 16'(d));
		chk("iter_default", 16'h04D8, iteration_count);
		host.wr_reg(REG_REQ, APP_MEAS);
		host.rd_reg(REG_APP, d);
		chk("app_held", 16'(APP_BOOT), 16'(d));
		for (int i = 0; i < 40 && d !== APP_MEAS; i++)
			host.rd_reg(REG_APP, d);
		chk("app_meas", 16'(APP_MEAS), 16'(d));
		host.rd_reg(REG_APP, d);
		host.rd_next(d);
		chk("revision", 16'h01, 16'(d));
		host.rd_next(d);
		chk("pointer_next", 16'(APP_MEAS), 16'(d));
		for (int i = 0; i < 16; i++)
			host.wr_reg(REG_CAL_BASE + 8'(i), 8'h11);
		host.rd_reg(REG_STATUS, d);
		chk("cal_loaded", 16'h1, 16'(d[ST_CAL_LOADED]));
		measure(8'h00, 16'd150, 1);
		measure(8'h05, 16'd300, 0);
		temp_changed = 1'b1;
		measure(8'hFF, 16'hFFFF, 1);
		near_st = 8'h5A;
		far_st = 8'h5A;
		host.wr_reg(REG_CMD, CMD_CALIBRATE);
		wait_bit(ST_CAL_DONE);
		host.rd_reg(REG_CAL_BASE + 8'h0F, d);
		chk("cal_byte", 16'h5A, 16'(d));
		host.wr_reg(REG_PERIOD, 8'hFF);
		host.rd_reg(REG_PERIOD, d);
		chk("period_clamp", 16'(PERIOD_MAX_MS), 16'(d));
		// Periodic ranging repeats after the wait, and stop ends it
		host.wr_reg(REG_PERIOD, 8'h28);
		host.wr_reg(REG_CMD, CMD_MEAS_PERIODIC);
		wait_bit(ST_RESULT);
		host.wr_reg(REG_STATUS, 8'h10);
		wait_bit(ST_RESULT);
		chk("periodic_busy", 16'h1, 16'(d[ST_BUSY]));
		host.wr_reg(REG_CMD, CMD_STOP);
		host.rd_reg(REG_STATUS, d);
		chk("stopped", 16'h0, 16'(d[ST_BUSY]));
		print_verdict();
	end
endmodule : ranging_app_control_tb_top
`default_nettype wire
